// ---- src/ulmc_pkg.sv ----
// shared constants and types for the line and modem control block
package ulmc_pkg;
  // register indices on the register port
  localparam logic [2:0] IDX_LINE_FMT = 3'h3;
  localparam logic [2:0] IDX_MODEM_CTL = 3'h4;
  // line_format_control fields
  localparam int LF_DLAB = 7;
  localparam int LF_BREAK = 6;
  localparam int LF_FORCE = 5;
  localparam int LF_EVEN = 4;
  localparam int LF_PAR_EN = 3;
  localparam int LF_STOP = 2;
  localparam int LF_WLEN_HI = 1;
  localparam int LF_WLEN_LO = 0;
  // modem_line_control fields
  localparam int MC_PRESC = 7;
  localparam int MC_IRDA = 6;
  localparam int MC_XANY = 5;
  localparam int MC_LOOP = 4;
  localparam int MC_RSVD = 3;
  localparam int MC_TRIG = 2;
  localparam int MC_RTS = 1;
  localparam int MC_DTR = 0;
  // bits that need the enhanced feature write enable
  localparam logic [7:0] MC_PROT_MASK = 8'he4;
  // bits that store anything
  localparam logic [7:0] MC_IMPL_MASK = 8'hf7;
  localparam logic [7:0] LINE_FMT_RST = 8'h00;
  localparam logic [7:0] MODEM_CTL_RST = 8'h00;
  // prescaler: divide by four
  localparam logic [1:0] PRESC_LAST = 2'h3;
  // stop length in half bit times
  localparam logic [2:0] STOP_ONE = 3'h2;
  localparam logic [2:0] STOP_ONE_HALF = 3'h3;
  localparam logic [2:0] STOP_TWO = 3'h4;
  localparam logic [3:0] WLEN_BASE = 4'h5;

  typedef struct packed {
    logic [3:0] data_bits;
    logic [2:0] stop_halves;
    logic parity_en;
    logic parity_forced;
    logic parity_even;
    logic irda_en;
    logic xon_any_en;
    logic trig_regs_en;
    logic divisor_access;
    logic loopback;
  } ulmc_fmt_s;
endpackage

// ---- src/ulmc_top.sv ----
// line format and modem control logic for one uart channel
//
// Contract
// - format top bit opens divisor latch access
// - break bit holds transmit line low outside loopback
// - parity enable adds and checks parity
// - type bit zero odd, one even
// - force bit fixes parity, inverse of type
// - stop select: 1, 1.5 or 2
// - word length field gives 5 to 8
// - prescale bit divides baud clock by four
// - infrared select picks sir encoding
// - any-character resume enable bit
// - loopback routes tx to rx, modem bits
// - trigger enable opens halt and trigger registers
// - rts bit drives rts low, or hardware, outside loopback
// - terminal-ready bit drives dtr when selected, outside loopback
// - pin level writes ignored on dtr pins
// - protected modem bits need enhanced enable
// - reset: no latch access, break, parity
`timescale 1ns/100ps
module ulmc_top (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [2:0] reg_idx,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic enh_wr_en,
  input wire logic tx_raw,
  output logic tx_pin,
  input wire logic rx_pin,
  output logic rx_core,
  input wire logic cts_n_pin,
  input wire logic dsr_n_pin,
  output logic cts_status,
  output logic dsr_status,
  input wire logic auto_rts_en,
  input wire logic auto_rts_n,
  output logic rts_n,
  input wire logic dtr_on_pin5,
  input wire logic dtr_on_pin1,
  input wire logic [7:0] pin_level_wdata,
  output logic pin5_out,
  output logic pin1_out,
  input wire logic [7:0] tx_char,
  output logic tx_parity,
  input wire logic [7:0] rx_char,
  input wire logic rx_par_bit,
  output logic rx_par_err,
  output ulmc_pkg::ulmc_fmt_s fmt,
  output logic baud_tick
);

  logic [7:0] line_format_control_ff;
  logic [7:0] modem_line_control_ff;
  logic [7:0] nxt_line_fmt;
  logic [7:0] nxt_modem_ctl;
  logic [1:0] presc_cnt_ff;
  logic loop_on;
  logic wr_line;
  logic wr_modem;

  // keep only the bits that belong to the selected word length
  function automatic logic [7:0] mask_char(input logic [7:0] c, input logic [1:0] wl);
    logic [7:0] m;
    m = 8'h1f;
    case (wl)
      2'h0: m = 8'h1f;
      2'h1: m = 8'h3f;
      2'h2: m = 8'h7f;
      2'h3: m = 8'hff;
      default: m = 8'hff;
    endcase
    return c & m;
  endfunction

  // parity bit for a character under the current format
  function automatic logic par_of(input logic [7:0] c, input logic [7:0] lf);
    logic p;
    p = ^mask_char(c, lf[ulmc_pkg::LF_WLEN_HI:ulmc_pkg::LF_WLEN_LO]);
    if (lf[ulmc_pkg::LF_FORCE]) begin
      return ~lf[ulmc_pkg::LF_EVEN];
    end
    if (lf[ulmc_pkg::LF_EVEN]) begin
      return p;
    end
    return ~p;
  endfunction

  assign wr_line = reg_wr && (reg_idx == ulmc_pkg::IDX_LINE_FMT);
  assign wr_modem = reg_wr && (reg_idx == ulmc_pkg::IDX_MODEM_CTL);
  assign loop_on = modem_line_control_ff[ulmc_pkg::MC_LOOP];

  always_comb begin
    nxt_line_fmt = line_format_control_ff;
    if (wr_line) begin
      nxt_line_fmt = reg_wdata;
    end
  end

  // protected bits keep their value unless the enhanced enable is set
  always_comb begin
    nxt_modem_ctl = modem_line_control_ff;
    if (wr_modem) begin
      if (enh_wr_en) begin
        nxt_modem_ctl = reg_wdata & ulmc_pkg::MC_IMPL_MASK;
      end else begin
        nxt_modem_ctl = (modem_line_control_ff & ulmc_pkg::MC_PROT_MASK)
          | (reg_wdata & ulmc_pkg::MC_IMPL_MASK & ~ulmc_pkg::MC_PROT_MASK);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      line_format_control_ff <= ulmc_pkg::LINE_FMT_RST;
    end else begin
      line_format_control_ff <= nxt_line_fmt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      modem_line_control_ff <= ulmc_pkg::MODEM_CTL_RST;
    end else begin
      modem_line_control_ff <= nxt_modem_ctl;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd && reg_idx == ulmc_pkg::IDX_LINE_FMT) begin
      reg_rdata <= line_format_control_ff;
    end else if (reg_rd && reg_idx == ulmc_pkg::IDX_MODEM_CTL) begin
      reg_rdata <= modem_line_control_ff;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // format decode for the shifters
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fmt <= '0;
    end else begin
      fmt.data_bits <= ulmc_pkg::WLEN_BASE
        + {2'h0, nxt_line_fmt[ulmc_pkg::LF_WLEN_HI:ulmc_pkg::LF_WLEN_LO]};
      if (!nxt_line_fmt[ulmc_pkg::LF_STOP]) begin
        fmt.stop_halves <= ulmc_pkg::STOP_ONE;
      end else if (nxt_line_fmt[ulmc_pkg::LF_WLEN_HI:ulmc_pkg::LF_WLEN_LO] == 2'h0) begin
        fmt.stop_halves <= ulmc_pkg::STOP_ONE_HALF;
      end else begin
        fmt.stop_halves <= ulmc_pkg::STOP_TWO;
      end
      fmt.parity_en <= nxt_line_fmt[ulmc_pkg::LF_PAR_EN];
      fmt.parity_forced <= nxt_line_fmt[ulmc_pkg::LF_FORCE];
      fmt.parity_even <= nxt_line_fmt[ulmc_pkg::LF_EVEN];
      fmt.divisor_access <= nxt_line_fmt[ulmc_pkg::LF_DLAB];
      fmt.irda_en <= nxt_modem_ctl[ulmc_pkg::MC_IRDA];
      fmt.xon_any_en <= nxt_modem_ctl[ulmc_pkg::MC_XANY];
      fmt.trig_regs_en <= nxt_modem_ctl[ulmc_pkg::MC_TRIG];
      fmt.loopback <= nxt_modem_ctl[ulmc_pkg::MC_LOOP];
    end
  end

  // parity generation and checking, zero while parity is off
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_parity <= 1'b0;
      rx_par_err <= 1'b0;
    end else if (line_format_control_ff[ulmc_pkg::LF_PAR_EN]) begin
      tx_parity <= par_of(tx_char, line_format_control_ff);
      rx_par_err <= par_of(rx_char, line_format_control_ff) != rx_par_bit;
    end else begin
      tx_parity <= 1'b0;
      rx_par_err <= 1'b0;
    end
  end

  // baud clock enable, every cycle or every fourth
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      presc_cnt_ff <= 2'h0;
    end else if (modem_line_control_ff[ulmc_pkg::MC_PRESC]) begin
      presc_cnt_ff <= presc_cnt_ff + 2'h1;
    end else begin
      presc_cnt_ff <= 2'h0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      baud_tick <= 1'b0;
    end else if (modem_line_control_ff[ulmc_pkg::MC_PRESC]) begin
      baud_tick <= presc_cnt_ff == ulmc_pkg::PRESC_LAST;
    end else begin
      baud_tick <= 1'b1;
    end
  end

  // serial path: break forces zero, loopback keeps the pin idle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_pin <= 1'b1;
      rx_core <= 1'b1;
    end else begin
      if (loop_on) begin
        tx_pin <= 1'b1;
        rx_core <= tx_raw & ~line_format_control_ff[ulmc_pkg::LF_BREAK];
      end else begin
        tx_pin <= tx_raw & ~line_format_control_ff[ulmc_pkg::LF_BREAK];
        rx_core <= rx_pin;
      end
    end
  end

  // modem status inputs are active low, reported active high
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cts_status <= 1'b0;
      dsr_status <= 1'b0;
    end else if (loop_on) begin
      cts_status <= modem_line_control_ff[ulmc_pkg::MC_RTS];
      dsr_status <= modem_line_control_ff[ulmc_pkg::MC_DTR];
    end else begin
      cts_status <= ~cts_n_pin;
      dsr_status <= ~dsr_n_pin;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rts_n <= 1'b1;
    end else if (loop_on) begin
      rts_n <= 1'b1;
    end else if (auto_rts_en) begin
      rts_n <= auto_rts_n;
    end else begin
      rts_n <= ~modem_line_control_ff[ulmc_pkg::MC_RTS];
    end
  end

  // general pins: terminal-ready wins over the pin level register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin5_out <= 1'b1;
      pin1_out <= 1'b1;
    end else begin
      if (dtr_on_pin5) begin
        pin5_out <= loop_on | ~modem_line_control_ff[ulmc_pkg::MC_DTR];
      end else begin
        pin5_out <= pin_level_wdata[5];
      end
      if (dtr_on_pin1) begin
        pin1_out <= loop_on | ~modem_line_control_ff[ulmc_pkg::MC_DTR];
      end else begin
        pin1_out <= pin_level_wdata[1];
      end
    end
  end

  chk_break_low: assert property (@(posedge sys_clk) disable iff (rst)
    line_format_control_ff[6] && !loop_on |=> !tx_pin)
    else $error("break not driving tx low");

  chk_prot_hold: assert property (@(posedge sys_clk) disable iff (rst)
    wr_modem && !enh_wr_en |=>
    (modem_line_control_ff & 8'he4) == ($past(modem_line_control_ff) & 8'he4))
    else $error("protected modem bits changed");

  chk_rsvd_zero: assert property (@(posedge sys_clk) disable iff (rst)
    modem_line_control_ff[3] == 1'b0)
    else $error("reserved bit stored");

  // switching the prescaler off mid-count is legal and ends the spacing check
  chk_presc_tick: assert property (@(posedge sys_clk)
    disable iff (rst || !modem_line_control_ff[7])
    modem_line_control_ff[7] && baud_tick && $past(modem_line_control_ff[7], 4)
    |=> !baud_tick [*3] ##1 baud_tick)
    else $error("prescaled tick spacing wrong");

  chk_presc_off: assert property (@(posedge sys_clk) disable iff (rst)
    !modem_line_control_ff[7] |=> baud_tick)
    else $error("undivided tick missing");

  chk_loop_status: assert property (@(posedge sys_clk) disable iff (rst)
    loop_on && $stable(modem_line_control_ff) |=>
    cts_status == $past(modem_line_control_ff[1])
    && dsr_status == $past(modem_line_control_ff[0]))
    else $error("loopback status mismatch");

  chk_loop_tx_idle: assert property (@(posedge sys_clk) disable iff (rst)
    loop_on |=> tx_pin)
    else $error("tx pin active in loopback");

  chk_loop_rx_path: assert property (@(posedge sys_clk) disable iff (rst)
    loop_on |=> rx_core == ($past(tx_raw) && !$past(line_format_control_ff[6])))
    else $error("loopback receive path wrong");

  chk_rts_drive: assert property (@(posedge sys_clk) disable iff (rst)
    !loop_on && !auto_rts_en |=> rts_n == !$past(modem_line_control_ff[1]))
    else $error("rts level wrong");

  chk_rts_auto: assert property (@(posedge sys_clk) disable iff (rst)
    !loop_on && auto_rts_en |=> rts_n == $past(auto_rts_n))
    else $error("hardware rts not followed");

  chk_dtr_pin: assert property (@(posedge sys_clk) disable iff (rst)
    dtr_on_pin5 && !loop_on |=> pin5_out == !$past(modem_line_control_ff[0]))
    else $error("dtr pin level wrong");

  chk_dtr_pin_one: assert property (@(posedge sys_clk) disable iff (rst)
    dtr_on_pin1 && !loop_on |=> pin1_out == !$past(modem_line_control_ff[0]))
    else $error("dtr level wrong on pin one");

  chk_forced_par: assert property (@(posedge sys_clk) disable iff (rst)
    line_format_control_ff[3] && line_format_control_ff[5]
    |=> tx_parity == !$past(line_format_control_ff[4]))
    else $error("forced parity wrong");

  chk_no_par: assert property (@(posedge sys_clk) disable iff (rst)
    !line_format_control_ff[3] |=> !tx_parity && !rx_par_err)
    else $error("parity active while off");

  chk_stop_len: assert property (@(posedge sys_clk) disable iff (rst)
    line_format_control_ff[2] && line_format_control_ff[1:0] == 2'h0
    && !wr_line |=> fmt.stop_halves == 3'h3)
    else $error("stop length wrong");

  chk_wlen_map: assert property (@(posedge sys_clk) disable iff (rst)
    wr_line |=> fmt.data_bits == 4'h5 + {2'h0, $past(reg_wdata[1:0])})
    else $error("word length wrong");

  chk_dlab_view: assert property (@(posedge sys_clk) disable iff (rst)
    wr_line |=> fmt.divisor_access == $past(reg_wdata[7]))
    else $error("divisor access not following");

  chk_irda_sel: assert property (@(posedge sys_clk) disable iff (rst)
    wr_modem && enh_wr_en |=> fmt.irda_en == $past(reg_wdata[6]))
    else $error("infrared select not following");

  chk_reset_regs: assert property (@(posedge sys_clk)
    rst |=> line_format_control_ff == 8'h00 && modem_line_control_ff == 8'h00)
    else $error("registers not cleared by reset");

endmodule

// ---- bench/ulmc_modem.sv ----
// far side model: a one-clock null-modem cable
`timescale 1ns/100ps
module ulmc_modem (
  input wire logic sys_clk,
  input wire logic tx_pin,
  input wire logic rts_n,
  output logic rx_pin,
  output logic cts_n_pin,
  output logic dsr_n_pin
);
  initial begin
    rx_pin = 1'b1;
    cts_n_pin = 1'b1;
    dsr_n_pin = 1'b0;
  end
  // tx wired back to rx, rts answered on cts
  always @(posedge sys_clk) begin
    rx_pin <= tx_pin;
    cts_n_pin <= rts_n;
  end
endmodule

// ---- bench/testbench.sv ----
// self-checking bench for the line and modem control block
`timescale 1ns/100ps
module testbench;
  localparam logic [2:0] LF = ulmc_pkg::IDX_LINE_FMT;
  localparam logic [2:0] MC = ulmc_pkg::IDX_MODEM_CTL;
  logic sys_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, enh_wr_en = 1'b0;
  logic [2:0] reg_idx = 3'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, pin_level_wdata = 8'h00;
  logic tx_raw = 1'b1, tx_pin, rx_pin, rx_core, cts_n_pin, dsr_n_pin, cts_status, dsr_status;
  logic auto_rts_en = 1'b0, auto_rts_n = 1'b0, rts_n, pin5_out, pin1_out, baud_tick;
  logic dtr_on_pin5 = 1'b0, dtr_on_pin1 = 1'b0, tx_parity, rx_par_bit = 1'b0, rx_par_err;
  logic [7:0] tx_char = 8'h00, rx_char = 8'h00, e, msk, v;
  logic rd_q = 1'b0, par;
  logic [7:0] exp_q[$];
  ulmc_pkg::ulmc_fmt_s fmt;
  int err_total = 0, checked = 0, n;
  always #2 sys_clk = ~sys_clk;
  ulmc_top dut (.sys_clk(sys_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_idx(reg_idx), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .enh_wr_en(enh_wr_en),
    .tx_raw(tx_raw), .tx_pin(tx_pin), .rx_pin(rx_pin), .rx_core(rx_core),
    .cts_n_pin(cts_n_pin), .dsr_n_pin(dsr_n_pin), .cts_status(cts_status),
    .dsr_status(dsr_status), .auto_rts_en(auto_rts_en), .auto_rts_n(auto_rts_n),
    .rts_n(rts_n), .dtr_on_pin5(dtr_on_pin5), .dtr_on_pin1(dtr_on_pin1),
    .pin_level_wdata(pin_level_wdata), .pin5_out(pin5_out), .pin1_out(pin1_out),
    .tx_char(tx_char), .tx_parity(tx_parity), .rx_char(rx_char), .rx_par_bit(rx_par_bit),
    .rx_par_err(rx_par_err), .fmt(fmt), .baud_tick(baud_tick));
  ulmc_modem modem (.sys_clk(sys_clk), .tx_pin(tx_pin), .rts_n(rts_n), .rx_pin(rx_pin),
    .cts_n_pin(cts_n_pin), .dsr_n_pin(dsr_n_pin));
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] ex);
    checked++;
    if (seen !== ex) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, seen);
    end
  endtask
  task step;
    @(posedge sys_clk);
    #1;
  endtask
  task wr(input logic [2:0] i, input logic [7:0] d);
    reg_wr = 1'b1;
    reg_idx = i;
    reg_wdata = d;
    step();
    reg_wr = 1'b0;
    step();
  endtask
  // expected read value is noted here and compared by the monitor
  task rd(input logic [2:0] i, input logic [7:0] ex);
    reg_rd = 1'b1;
    reg_idx = i;
    exp_q.push_back(ex);
    step();
    reg_rd = 1'b0;
    step();
  endtask
  always @(posedge sys_clk) rd_q <= reg_rd;
  always @(negedge sys_clk) begin
    if (rd_q) begin
      e = exp_q.pop_front();
      chk("reg_rdata", reg_rdata, e);
    end
  end
  task end_of_test;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge sys_clk);
    err_total++;
    end_of_test();
  end
  initial begin
    v = $urandom(32'h844a3a26);
    repeat (3) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    rd(LF, 8'h00);
    rd(MC, 8'h00);
    rd(3'h5, 8'h00);
    chk("tx_pin", tx_pin, 1'b1);
    $display("test reset done");
    for (int m = 0; m < 16; m++) begin
      v = {2'b00, m[3:2], 1'b1, m[2] ^ m[0], m[1:0]};
      wr(LF, v);
      rd(LF, v);
      tx_char = $urandom;
      rx_char = tx_char;
      rx_par_bit = $urandom;
      step();
      msk = tx_char & (8'hff >> (3 - m[1:0]));
      par = m[3] ? ~m[2] : (m[2] ? ^msk : ~^msk);
      chk("data_bits", fmt.data_bits, 4'h5 + m[1:0]);
      chk("stop_halves", fmt.stop_halves, v[2] ? (m[1:0] == 0 ? 3 : 4) : 2);
      chk("tx_parity", tx_parity, par);
      chk("rx_par_err", rx_par_err, rx_par_bit ^ par);
      chk("par_fields", {fmt.parity_en, fmt.parity_forced, fmt.parity_even}, {1'b1, m[3], m[2]});
    end
    wr(LF, 8'h87);
    step();
    chk("divisor_access", fmt.divisor_access, 1'b1);
    chk("tx_parity", tx_parity, 1'b0);
    chk("rx_par_err", rx_par_err, 1'b0);
    chk("parity_en", fmt.parity_en, 1'b0);
    wr(LF, 8'h40);
    step();
    chk("tx_pin", tx_pin, 1'b0);
    wr(LF, 8'h00);
    chk("tx_pin", tx_pin, 1'b1);
    chk("divisor_access", fmt.divisor_access, 1'b0);
    $display("test line format done");
    wr(MC, 8'hff);
    rd(MC, 8'h13);
    enh_wr_en = 1'b1;
    wr(MC, 8'h6c);
    rd(MC, 8'h64);
    chk("irda_xon_trig", {fmt.irda_en, fmt.xon_any_en, fmt.trig_regs_en}, 3'h7);
    for (int p = 0; p < 2; p++) begin
      wr(MC, {p[0], 7'h00});
      n = 0;
      repeat (8) begin
        step();
        n += baud_tick;
      end
      chk("baud_ticks", n[7:0], p ? 8'h02 : 8'h08);
    end
    $display("test modem bits done");
    wr(MC, 8'h13);
    tx_raw = 1'b0;
    step();
    chk("rx_core", rx_core, 1'b0);
    chk("status", {cts_status, dsr_status, rts_n, tx_pin}, 4'hf);
    chk("loopback", fmt.loopback, 1'b1);
    wr(MC, 8'h10);
    chk("status", {cts_status, dsr_status}, 2'h0);
    wr(MC, 8'h03);
    dtr_on_pin5 = 1'b1;
    pin_level_wdata = 8'h22;
    repeat (3) step();
    chk("rx_core", rx_core, 1'b0);
    chk("rts_n", rts_n, 1'b0);
    chk("pins", {pin5_out, pin1_out}, 2'h1);
    chk("status", {cts_status, dsr_status}, 2'h3);
    auto_rts_en = 1'b1;
    auto_rts_n = 1'b1;
    dtr_on_pin1 = 1'b1;
    wr(MC, 8'h02);
    chk("rts_n", rts_n, 1'b1);
    chk("pins", {pin5_out, pin1_out}, 2'h3);
    $display("test modem lines done");
    tx_raw = 1'b1;
    wr(LF, 8'hc8);
    rst = 1'b1;
    repeat (2) step();
    rst = 1'b0;
    rd(LF, 8'h00);
    rd(MC, 8'h00);
    chk("tx_pin", tx_pin, 1'b1);
    chk("reset_fmt", {fmt.divisor_access, fmt.parity_en, tx_parity}, 3'h0);
    $display("test mid-run reset done");
    end_of_test();
  end
endmodule
